// ---- boot_control_address_map.sv ----
// Purpose: Boot-mode sequencing, CPU stall control and registered address decode
// Assumes: Pin inputs are asynchronous and pass two flip-flops first
// Notes:   Host port control bit is modelled as a register here
`timescale 1ns/1ps
module boot_control_address_map (
	input  wire logic                              clk,
	input  wire logic                              reset,
	input  wire logic [1:0]                        boot_mode_pins,       // Boot strap
	input  wire logic                              pci_select_pin,      // Low enables host port
	input  wire logic                              host_set_int,        // Host writes interrupt bit
	input  wire logic                              cpu_clear_int,       // CPU clears interrupt bit
	input  wire logic                              host_access_req,     // Host memory access
	input  wire logic [31:0]                       host_access_addr,
	input  wire logic                              host_access_write,
	input  wire logic [31:0]                       host_access_wdata,
	input  wire logic [31:0]                       target_rdata,        // Read data from the hit target
	input  wire logic [31:0]                       cpu_addr,            // CPU address to decode
	output logic                                   cpu_stall,
	output logic                                   cpu_run,
	output logic [31:0]                            cpu_fetch_addr,
	output logic [2:0]                             rom_width,
	output logic                                   host_port_enable,
	output logic                                   host_to_cpu_interrupt_bit,
	output logic                                   cpu_int_pending,
	output logic                                   host_access_ack,
	output logic [31:0]                            host_access_rdata,
	output logic [boot_map_pkg::TARGET_W-1:0]      host_target,
	output logic                                   host_wr_strobe,
	output logic [31:0]                            host_wr_data,
	output logic [boot_map_pkg::TARGET_W-1:0]      cpu_target,
	output logic                                   cpu_reserved,
	output logic                                   serial_pins_gpio,
	output logic                                   clock_pin_gpio,
	output logic                                   mac_pins_mac,
	output logic                                   rgmii_selected
);
	// Two wait phases let the strap synchroniser fill before the mode is taken
	typedef enum logic [2:0] {S_SYNC_A, S_SYNC_B, S_SAMPLE, S_STALL, S_RUN} phase_t;

	typedef struct packed {
		logic [1:0]                       mode_m;   // Strap sync stage one
		logic [1:0]                       mode_s;
		logic                             pci_m;
		logic                             pci_s;
		phase_t                           phase;
		boot_map_pkg::boot_mode_t         mode;
		logic                             stall;
		logic                             run;
		logic [31:0]                      fetch;
		logic [2:0]                       romw;
		logic                             hp_en;
		logic                             int_bit;
		logic                             pend;
		logic                             ack;
		logic [31:0]                      rdata;
		logic [boot_map_pkg::TARGET_W-1:0] htgt;
		logic                             wstb;
		logic [31:0]                      wdata;
		logic [boot_map_pkg::TARGET_W-1:0] ctgt;
		logic                             cres;
	} state_t;

	state_t s_r;   // All registered state
	state_t s_nxt; // Next value

	dec_if hdec ();
	dec_if cdec ();
	assign hdec.addr = host_access_addr;
	assign cdec.addr = cpu_addr;

	// Host-side and CPU-side decoders share one decode function set
	addr_decoder u_hdec (.d(hdec.decoder));
	addr_decoder u_cdec (.d(cdec.decoder));

	// Next-state logic for boot sequencing, interrupt bit and access service
	always_comb begin
		s_nxt = s_r;
		s_nxt.mode_m = boot_mode_pins;
		s_nxt.mode_s = s_r.mode_m;
		s_nxt.pci_m  = pci_select_pin;
		s_nxt.pci_s  = s_r.pci_m;
		s_nxt.ack    = 1'b0;
		s_nxt.wstb   = 1'b0;
		s_nxt.ctgt   = cdec.target;
		s_nxt.cres   = cdec.reserved;
		case (s_r.phase)
			S_SYNC_A: begin
				// Synchroniser still shows its reset value here
				s_nxt.phase = S_SYNC_B;
			end
			S_SYNC_B: begin
				// Second stage loads the strap at this edge
				s_nxt.phase = S_SAMPLE;
			end
			S_SAMPLE: begin
				// Mode taken once, after release, from the synchronised strap
				s_nxt.mode  = boot_map_pkg::boot_mode_t'(s_r.mode_s);
				s_nxt.hp_en = ~s_r.pci_s;
				case (boot_map_pkg::boot_mode_t'(s_r.mode_s))
					boot_map_pkg::BOOT_HOST: begin
						s_nxt.phase = S_STALL;
						s_nxt.stall = 1'b1;
					end
					boot_map_pkg::BOOT_ROM: begin
						s_nxt.phase = S_RUN;
						s_nxt.run   = 1'b1;
						s_nxt.fetch = boot_map_pkg::ROM_VECTOR;
						s_nxt.romw  = boot_map_pkg::ROM_WIDTH_8;
					end
					default: begin
						// Undefined strap code behaves as no boot
						s_nxt.mode  = boot_map_pkg::BOOT_NONE;
						s_nxt.phase = S_RUN;
						s_nxt.run   = 1'b1;
						s_nxt.fetch = boot_map_pkg::RESET_VECTOR;
					end
				endcase
			end
			S_STALL: begin
				// Host bit set ends the stall; only host mode reaches here
				if (s_r.int_bit && s_r.mode == boot_map_pkg::BOOT_HOST) begin
					s_nxt.phase = S_RUN;
					s_nxt.stall = 1'b0;
					s_nxt.run   = 1'b1;
					s_nxt.fetch = boot_map_pkg::RESET_VECTOR;
				end
			end
			S_RUN: begin
				s_nxt.phase = S_RUN;
			end
			default: begin
				s_nxt.phase = S_SAMPLE;
			end
		endcase
		// CPU clear first, so that a host set in the same cycle wins
		if (cpu_clear_int && s_r.phase == S_RUN) begin
			s_nxt.int_bit = 1'b0;
			s_nxt.pend    = 1'b0;
		end
		// Held set blocks new interrupts from becoming pending
		if (host_set_int && s_r.hp_en) begin
			s_nxt.int_bit = 1'b1;
			if (!s_r.int_bit && s_r.phase == S_RUN) begin
				s_nxt.pend = 1'b1;
			end
		end
		// Host access, serviced in stall and run phases alike once hp_en is set; a request still held while ack shows is not taken again
		if (host_access_req && s_r.hp_en && !s_r.ack) begin
			s_nxt.ack   = 1'b1;
			s_nxt.htgt  = hdec.target;
			s_nxt.wstb  = host_access_write && !hdec.reserved;
			s_nxt.wdata = host_access_wdata;
			s_nxt.rdata = (hdec.reserved || host_access_write) ? 32'h0000_0000 : target_rdata;
		end
	end

	// State register; reset loads constants only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flip-flops; pin default outputs are constants
	assign cpu_stall                 = s_r.stall;
	assign cpu_run                   = s_r.run;
	assign cpu_fetch_addr            = s_r.fetch;
	assign rom_width                 = s_r.romw;
	assign host_port_enable          = s_r.hp_en;
	assign host_to_cpu_interrupt_bit = s_r.int_bit;
	assign cpu_int_pending           = s_r.pend;
	assign host_access_ack           = s_r.ack;
	assign host_access_rdata         = s_r.rdata;
	assign host_target               = s_r.htgt;
	assign host_wr_strobe            = s_r.wstb;
	assign host_wr_data              = s_r.wdata;
	assign cpu_target                = s_r.ctgt;
	assign cpu_reserved              = s_r.cres;
	assign serial_pins_gpio          = ~boot_map_pkg::PIN_GPIO;
	assign clock_pin_gpio            = ~boot_map_pkg::PIN_GPIO;
	assign mac_pins_mac              = ~boot_map_pkg::PIN_MAC;
	assign rgmii_selected            = boot_map_pkg::PIN_MAC;

	// Stall held while host mode waits for the bit
	a_stall_hold: assert property (@(posedge clk) disable iff (reset)
		(s_r.phase == S_STALL && !s_r.int_bit) |=> s_r.stall)
		else $error("stall dropped without interrupt bit");
	a_stall_release: assert property (@(posedge clk) disable iff (reset)
		(s_r.phase == S_STALL && s_r.int_bit) |=> (!s_r.stall && s_r.run && s_r.fetch == 32'h0))
		else $error("stall not released to address zero");
	a_host_only: assert property (@(posedge clk) disable iff (reset)
		s_r.stall |-> s_r.mode == boot_map_pkg::BOOT_HOST)
		else $error("stall outside host boot");
	a_no_pend: assert property (@(posedge clk) disable iff (reset)
		(s_r.phase != S_RUN) |=> !s_r.pend)
		else $error("interrupt latched during stall");
	a_bit_sticky: assert property (@(posedge clk) disable iff (reset)
		(s_r.int_bit && !cpu_clear_int) |=> s_r.int_bit)
		else $error("interrupt bit lost");
	a_rom_vec: assert property (@(posedge clk) disable iff (reset)
		(s_r.run && s_r.mode == boot_map_pkg::BOOT_ROM) |-> s_r.fetch == 32'hB000_0000)
		else $error("rom boot wrong vector");
	a_host_ack: assert property (@(posedge clk) disable iff (reset)
		(host_access_req && s_r.hp_en && !s_r.ack) |=> s_r.ack)
		else $error("host access not serviced");
	a_ack_pulse: assert property (@(posedge clk) disable iff (reset)
		s_r.ack |=> !s_r.ack)
		else $error("host access taken twice");
	a_rsv_zero: assert property (@(posedge clk) disable iff (reset)
		(s_r.ack && s_r.htgt == '0) |-> (s_r.rdata == 32'h0 && !s_r.wstb))
		else $error("reserved access had effect");
	a_one_boot: assert property (@(posedge clk) disable iff (reset)
		$rose(s_r.run) |-> ##1 $stable(s_r.mode))
		else $error("boot mode changed after start");
endmodule : boot_control_address_map

// ---- boot_map_pkg.sv ----
// Purpose: Constants for the boot sequencer and the system address decoder
// Assumes: 32-bit byte addresses, one system clock
// Notes:   What this block does is listed below
//
// What this block does
// - Reset held high keeps everything at defaults
// - Reset release starts CPU with sampled mode
// - Exactly three boot modes: host, ROM, none
// - Host boot stalls CPU, rest leaves reset
// - Host port serviced during the stall
// - Host port enabled only when PCI-select low
// - Interrupt bit releases stall, fetch at zero
// - Interrupt during stall is not latched pending
// - Stall release only in host boot mode
// - Bit stays set until CPU clears it
// - ROM boot runs from 8-bit chip-select three
// - No boot runs directly from address zero
// - Decode 2 MB level-two SRAM window
// - Decode both memory port configuration windows
// - Chip-select two to five, 256 MB each
// - Chip-select zero and one never selected
// - Decode 256 MB DDR2 SDRAM window
// - Decode UTOPIA receive and transmit windows
// - Serial port pins default to general I/O
// - Divided clock pin defaults to general I/O
// - MAC pins default to MAC, RGMII exclusive
package boot_map_pkg;
	typedef enum logic [1:0] {BOOT_NONE, BOOT_HOST, BOOT_ROM, BOOT_BAD} boot_mode_t;
	localparam logic [31:0] RESET_VECTOR   = 32'h0000_0000;
	localparam logic [31:0] ROM_VECTOR     = 32'hB000_0000;
	localparam logic [31:0] L2_BASE        = 32'h0080_0000;
	localparam logic [31:0] L2_LIMIT       = 32'h009F_FFFF;
	localparam logic [31:0] PMP_CFG_BASE   = 32'h7000_0000;
	localparam logic [31:0] PMP_CFG_LIMIT  = 32'h77FF_FFFF;
	localparam logic [31:0] DDR_CFG_BASE   = 32'h7800_0000;
	localparam logic [31:0] DDR_CFG_LIMIT  = 32'h7FFF_FFFF;
	localparam logic [31:0] CS_LOW         = 32'hA000_0000;
	localparam logic [31:0] CS_HIGH        = 32'hDFFF_FFFF;
	localparam logic [31:0] DDR_BASE       = 32'hE000_0000;
	localparam logic [31:0] DDR_LIMIT      = 32'hEFFF_FFFF;
	localparam logic [31:0] UT_RX_BASE     = 32'h3C00_0000;
	localparam logic [31:0] UT_RX_LIMIT    = 32'h3C00_03FF;
	localparam logic [31:0] UT_TX_BASE     = 32'h3C00_0400;
	localparam logic [31:0] UT_TX_LIMIT    = 32'h3C00_07FF;
	localparam int          CS_SEL_MSB     = 29;
	localparam int          CS_SEL_LSB     = 28;
	localparam int          CS_FIRST       = 2;
	localparam int          TARGET_W       = 12;
	localparam int          T_L2           = 0;
	localparam int          T_PMP_CFG      = 1;
	localparam int          T_DDR_CFG      = 2;
	localparam int          T_CS2          = 3;
	localparam int          T_CS3          = 4;
	localparam int          T_CS4          = 5;
	localparam int          T_CS5          = 6;
	localparam int          T_DDR          = 7;
	localparam int          T_UT_RX        = 8;
	localparam int          T_UT_TX        = 9;
	localparam int          T_CS0          = 10;
	localparam int          T_CS1          = 11;
	localparam logic [2:0]  ROM_WIDTH_8    = 3'h0;
	localparam logic        PIN_GPIO       = 1'h0;
	localparam logic        PIN_MAC        = 1'h0;
endpackage : boot_map_pkg

// ---- dec_if.sv ----
// Purpose: Carries the address and the decoded target lines
// Assumes: Combinational decode between two modules
// Notes:   Main module drives addr, decoder drives the rest
`timescale 1ns/1ps
interface dec_if;
	logic [31:0]                      addr;     // Address under decode
	logic [boot_map_pkg::TARGET_W-1:0] target;  // One-hot target
	logic                             reserved; // No target hit
	modport requester (output addr, input target, input reserved);
	modport decoder (input addr, output target, output reserved);
endinterface : dec_if

// ---- addr_decoder.sv ----
// Purpose: Decodes a system address into a one-hot target
// Assumes: Purely combinational
// Notes:   Chip-select zero and one lines are never set
`timescale 1ns/1ps
module addr_decoder (
	dec_if.decoder d
);
	// Inclusive range test, used for every window
	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	logic [1:0] cs_idx; // Which of the four 256 MB chip-select windows
	logic [boot_map_pkg::TARGET_W-1:0] t;

	// Window decode; everything else falls to reserved
	always_comb begin
		t = '0;
		// Window A000_0000 is chip-select two, so rebase the select bits to zero there
		cs_idx = d.addr[boot_map_pkg::CS_SEL_MSB:boot_map_pkg::CS_SEL_LSB] - 2'(boot_map_pkg::CS_FIRST);
		t[boot_map_pkg::T_L2]      = in_range(d.addr, boot_map_pkg::L2_BASE, boot_map_pkg::L2_LIMIT);
		t[boot_map_pkg::T_PMP_CFG] = in_range(d.addr, boot_map_pkg::PMP_CFG_BASE,
			boot_map_pkg::PMP_CFG_LIMIT);
		t[boot_map_pkg::T_DDR_CFG] = in_range(d.addr, boot_map_pkg::DDR_CFG_BASE,
			boot_map_pkg::DDR_CFG_LIMIT);
		if (in_range(d.addr, boot_map_pkg::CS_LOW, boot_map_pkg::CS_HIGH)) begin
			t[boot_map_pkg::T_CS2 + int'(cs_idx)] = 1'b1;
		end
		t[boot_map_pkg::T_DDR]   = in_range(d.addr, boot_map_pkg::DDR_BASE, boot_map_pkg::DDR_LIMIT);
		t[boot_map_pkg::T_UT_RX] = in_range(d.addr, boot_map_pkg::UT_RX_BASE, boot_map_pkg::UT_RX_LIMIT);
		t[boot_map_pkg::T_UT_TX] = in_range(d.addr, boot_map_pkg::UT_TX_BASE, boot_map_pkg::UT_TX_LIMIT);
		t[boot_map_pkg::T_CS0] = 1'b0;
		t[boot_map_pkg::T_CS1] = 1'b0;
		d.target   = t;
		d.reserved = (t == '0);
	end
endmodule : addr_decoder

// ---- host_model.sv ----
// Purpose: Behavioural external host on the host port
// Assumes: One access at a time, held until acknowledged
// Notes:   Target read data is the inverse of the address
`timescale 1ns/1ps
module host_model (
	input  wire logic        clk,
	input  wire logic        host_access_ack,
	input  wire logic [31:0] host_access_rdata,
	output logic             host_access_req,
	output logic [31:0]      host_access_addr,
	output logic             host_access_write,
	output logic [31:0]      host_access_wdata,
	output logic             host_set_int,
	output logic [31:0]      target_rdata
);
	// Memory behind the decoder answers with the inverted address
	assign target_rdata = ~host_access_addr;
	// Idle host at time zero
	initial begin
		host_access_req   = 1'h0;
		host_access_addr  = 32'h0;
		host_access_write = 1'h0;
		host_access_wdata = 32'h0;
		host_set_int      = 1'h0;
	end
	// One access, held until ack is sampled or the bound runs out
	task automatic access(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		ok = 1'h0;
		q = 32'h0;
		@(posedge clk);
		host_access_req   <= 1'h1;
		host_access_addr  <= a;
		host_access_write <= w;
		host_access_wdata <= d;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge clk);
			// Read data is taken at the edge that shows ack
			if (host_access_ack === 1'h1) begin
				ok = 1'h1;
				q = host_access_rdata;
			end
		end
		// Released address and write data lines show the inverse of the last value
		host_access_req   <= 1'h0;
		host_access_addr  <= ~a;
		host_access_wdata <= ~d;
	endtask : access
	// Host writes the interrupt bit to end the boot
	task automatic pulse_int;
		@(posedge clk);
		host_set_int <= 1'h1;
		@(posedge clk);
		host_set_int <= 1'h0;
	endtask : pulse_int
endmodule : host_model

// ---- tb.sv ----
// Purpose: Self-checking bench for boot sequencing and address decode
// Assumes: Host model drives the host port, bench drives straps and CPU side
// Notes:   Decode cases are table rows, boot cases are hand-written
`timescale 1ns/1ps
module tb;
	typedef struct packed {logic [31:0] a; logic [11:0] t;} row_t; // Address and expected one-hot
	logic        clk, reset, pci_select_pin, host_set_int, cpu_clear_int, host_access_req, host_access_write;
	logic [1:0]  boot_mode_pins;
	logic [31:0] host_access_addr, host_access_wdata, target_rdata, cpu_addr, cpu_fetch_addr;
	logic [31:0] host_access_rdata, host_wr_data, q;
	logic        cpu_stall, cpu_run, host_port_enable, host_to_cpu_interrupt_bit, cpu_int_pending, ok;
	logic        host_access_ack, host_wr_strobe, cpu_reserved, serial_pins_gpio, clock_pin_gpio;
	logic        mac_pins_mac, rgmii_selected;
	logic [2:0]  rom_width;
	logic [boot_map_pkg::TARGET_W-1:0] host_target, cpu_target;
	int          err_count, n_checks, cycles, n_wstb;
	// Decode rows: both ends of the L2, configuration and DDR windows, one end of each chip-select and UTOPIA window, and neighbouring reserved places
	row_t rows [20] = '{'{32'h0080_0000, 12'h001}, '{32'h009F_FFFF, 12'h001}, '{32'h00A0_0000, 12'h000},
		'{32'h007F_FFFF, 12'h000}, '{32'h7000_0000, 12'h002}, '{32'h77FF_FFFF, 12'h002},
		'{32'h7800_0000, 12'h004}, '{32'h7FFF_FFFF, 12'h004}, '{32'hA000_0000, 12'h008},
		'{32'hB000_0000, 12'h010}, '{32'hC000_0000, 12'h020}, '{32'hDFFF_FFFF, 12'h040},
		'{32'h9FFF_FFFF, 12'h000}, '{32'hE000_0000, 12'h080}, '{32'hEFFF_FFFF, 12'h080},
		'{32'hF000_0000, 12'h000}, '{32'h3C00_0000, 12'h100}, '{32'h3C00_07FF, 12'h200},
		'{32'h3C00_0800, 12'h000}, '{32'h6FFF_FFFF, 12'h000}};
	boot_control_address_map boot_control_address_map_inst (.clk(clk), .reset(reset),
		.boot_mode_pins(boot_mode_pins), .pci_select_pin(pci_select_pin), .host_set_int(host_set_int),
		.cpu_clear_int(cpu_clear_int), .host_access_req(host_access_req), .host_access_addr(host_access_addr),
		.host_access_write(host_access_write), .host_access_wdata(host_access_wdata),
		.target_rdata(target_rdata), .cpu_addr(cpu_addr), .cpu_stall(cpu_stall), .cpu_run(cpu_run),
		.cpu_fetch_addr(cpu_fetch_addr), .rom_width(rom_width), .host_port_enable(host_port_enable),
		.host_to_cpu_interrupt_bit(host_to_cpu_interrupt_bit), .cpu_int_pending(cpu_int_pending),
		.host_access_ack(host_access_ack), .host_access_rdata(host_access_rdata), .host_target(host_target),
		.host_wr_strobe(host_wr_strobe), .host_wr_data(host_wr_data), .cpu_target(cpu_target),
		.cpu_reserved(cpu_reserved), .serial_pins_gpio(serial_pins_gpio), .clock_pin_gpio(clock_pin_gpio),
		.mac_pins_mac(mac_pins_mac), .rgmii_selected(rgmii_selected));
	host_model host_model_inst (.clk(clk), .host_access_ack(host_access_ack),
		.host_access_rdata(host_access_rdata), .host_access_req(host_access_req),
		.host_access_addr(host_access_addr), .host_access_write(host_access_write),
		.host_access_wdata(host_access_wdata), .host_set_int(host_set_int), .target_rdata(target_rdata));
	// 200 MHz system clock
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end
	// Counts write strobes seen, one per taken host write to a non-reserved address
	always @(posedge clk) begin
		if (host_wr_strobe === 1'h1) begin
			n_wstb++;
		end
	end
	// Compare seen against expected, four-state
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Counts and verdict, then end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	// Reset for 4 cycles with the straps set, check defaults, then let the boot sample land
	task automatic boot(input logic [1:0] m, input logic p);
		@(posedge clk);
		reset <= 1'h1;
		boot_mode_pins <= m;
		pci_select_pin <= p;
		repeat (4) @(posedge clk);
		check("run_in_reset", cpu_run, 1'h0);
		check("int_in_reset", host_to_cpu_interrupt_bit, 1'h0);
		check("serial_gpio", serial_pins_gpio, 1'h1);
		check("clock_gpio", clock_pin_gpio, 1'h1);
		check("mac_pins", {mac_pins_mac, rgmii_selected}, 2'h2);
		reset <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
	endtask : boot
	// CPU side pulse that clears the interrupt bit
	task automatic clear_int;
		@(posedge clk);
		cpu_clear_int <= 1'h1;
		@(posedge clk);
		cpu_clear_int <= 1'h0;
		@(posedge clk);
		#1;
	endtask : clear_int
	// Settle two edges after an interrupt pulse
	task automatic raise_int;
		host_model_inst.pulse_int();
		repeat (2) @(posedge clk);
		#1;
	endtask : raise_int
	// Main sequence
	initial begin
		reset = 1'h1;
		boot_mode_pins = 2'h1;
		pci_select_pin = 1'h0;
		cpu_clear_int = 1'h0;
		cpu_addr = 32'h0;
		boot(2'h1, 1'h0);
		check("stall", {cpu_stall, cpu_run, host_port_enable}, 3'h5);
		host_model_inst.access(32'h0080_0010, 1'h1, 32'h1234_5678, q, ok);
		#1;
		check("wr_data", host_wr_data, 32'h1234_5678);
		check("wr_strobes", n_wstb, 32'h1);
		host_model_inst.access(32'h0080_0010, 1'h0, 32'h0, q, ok);
		#1;
		check("rd_data", q, 32'hFF7F_FFEF);
		check("host_target", host_target, 12'h001);
		host_model_inst.access(32'h0000_0100, 1'h0, 32'h0, q, ok);
		check("rsv_ok", ok, 1'h1);
		check("rsv_read", q, 32'h0);
		host_model_inst.access(32'h0000_0100, 1'h1, 32'hA5A5_A5A5, q, ok);
		#1;
		check("rsv_write", n_wstb, 32'h1);
		raise_int();
		check("released", {cpu_stall, cpu_run, host_to_cpu_interrupt_bit}, 3'h3);
		check("fetch", cpu_fetch_addr, 32'h0);
		check("no_pend", cpu_int_pending, 1'h0);
		raise_int();
		check("second_int", {host_to_cpu_interrupt_bit, cpu_int_pending}, 2'h2);
		clear_int();
		check("cleared", host_to_cpu_interrupt_bit, 1'h0);
		raise_int();
		check("run_pend", cpu_int_pending, 1'h1);
		$display("test host_boot done");
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			cpu_addr <= rows[i].a;
			@(posedge clk);
			#1;
			check("cpu_target", cpu_target, rows[i].t);
			check("cpu_reserved", cpu_reserved, rows[i].t == 12'h000);
		end
		$display("test decode done");
		boot(2'h2, 1'h0);
		check("rom_run", {cpu_stall, cpu_run, rom_width}, 5'h08);
		check("rom_fetch", cpu_fetch_addr, 32'hB000_0000);
		raise_int();
		check("rom_int", {cpu_stall, cpu_run}, 2'h1);
		$display("test rom_boot done");
		for (int m = 0; m < 4; m += 3) begin
			boot(2'(m), 1'h0);
			check("none_run", {cpu_stall, cpu_run}, 2'h1);
			check("none_fetch", cpu_fetch_addr, 32'h0);
		end
		$display("test no_boot done");
		boot(2'h1, 1'h1);
		check("port_off", host_port_enable, 1'h0);
		host_model_inst.access(32'h0080_0000, 1'h0, 32'h0, q, ok);
		check("refused", ok, 1'h0);
		$display("test pci_select done");
		stop_test();
	end
endmodule : tb
